// ==== rtl/clwps_top.sv ====
// clwps_top: cpu clock source select with clock-loss watchdog, AXI4-Lite registers
// assumes: all inputs synchronous to mclk except ext_clock_input_pin; pll modelled as mclk divider
//
// The address map and the AXI4-Lite register port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "clwps_regs.svh"
module clwps_top
    import clwps_pkg::*;
#(
    parameter int unsigned ADDR_W   = `CLWPS_ADDR_W,
    parameter int unsigned PLL_HALF = `CLWPS_PLL_HALF,
    parameter int unsigned HP_W     = 16
)(
    input  wire logic              mclk,
    input  wire logic              reset_n,
    input  wire logic              ext_clock_input_pin,
    input  wire logic [2:0]        clock_mode_strap_pins,
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    output logic                   cpu_clk,
    output logic                   pll_enable,
    output logic                   cpu_on_pll,
    output logic                   clock_fail_irq
);
    localparam int SW_MAX = PLL_HALF + 2;

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!reset_n);

    function automatic logic [3:0] strap_f2(input logic [2:0] code);
        // multiplication factor times two, so 1.5 and 2.5 stay integer
        case (code)
            3'h7:    strap_f2 = 4'h8;
            3'h6:    strap_f2 = 4'h6;
            3'h5:    strap_f2 = 4'h4;
            3'h4:    strap_f2 = 4'hA;
            3'h2:    strap_f2 = 4'h3;
            3'h0:    strap_f2 = 4'h5;
            default: strap_f2 = 4'h2;
        endcase
    endfunction : strap_f2

    function automatic clwps_mode_e strap_mode(input logic [2:0] code);
        if (code == `CLWPS_STRAP_DIRECT)
            strap_mode = CLK_DIRECT;
        else if (code == `CLWPS_STRAP_PRESC)
            strap_mode = CLK_PRESC;
        else
            strap_mode = CLK_PLL;
    endfunction : strap_mode

    function automatic logic addr_hit(input logic [ADDR_W-1:0] a);
        addr_hit = (a == ADDR_W'(`CLWPS_OFF_CONFIG)) || (a == ADDR_W'(`CLWPS_OFF_STATUS))
                || (a == ADDR_W'(`CLWPS_OFF_MASK)) || (a == ADDR_W'(`CLWPS_OFF_INFO));
    endfunction : addr_hit

    ////////////////////////////////////////////////////////////////////////////
    // strap capture

    logic        strap_done_ff;
    logic [2:0]  strap_ff;
    clwps_mode_e mode_ff;
    logic [3:0]  f2_ff;

    // straps are latched at the first edge after release: an async reset may only load constants
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            strap_done_ff <= 1'b0;
            strap_ff      <= `CLWPS_STRAP_RST;
            mode_ff       <= CLK_PLL;
            f2_ff         <= strap_f2(`CLWPS_STRAP_RST);
        end
        else if (!strap_done_ff)
        begin
            strap_done_ff <= 1'b1; // RL17
            strap_ff      <= clock_mode_strap_pins;
            mode_ff       <= strap_mode(clock_mode_strap_pins); // RL14 RL15 RL12
            f2_ff         <= strap_f2(clock_mode_strap_pins);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // input clock sampling and monitor control

    logic xtal_lvl;
    logic xtal_edge;

    clwps_sync u_sync (
        .clk     (mclk),
        .reset_n (reset_n),
        .d_in    (ext_clock_input_pin),
        .level   (xtal_lvl),
        .toggle  (xtal_edge)
    ); // RL16

    logic        dis_ff;
    logic        fail_ff;
    logic        pll_on_ff;
    logic        pll_clk_ff;
    logic [7:0]  pll_div_ff;
    logic        pll_tick;
    logic        direct_mode;
    logic        mon_on;
    logic        pll_on_nxt;
    clwps_mon_if mon_if ();

    assign direct_mode = strap_done_ff && (mode_ff != CLK_PLL);
    assign mon_on      = direct_mode && !dis_ff && !fail_ff; // RL1 RL3
    // once failed the pll stays on even if software disables the monitor
    assign pll_on_nxt  = strap_done_ff && ((mode_ff == CLK_PLL) || (direct_mode && (!dis_ff || fail_ff))); // RL11 RL12
    assign pll_tick    = pll_on_ff && !pll_clk_ff && (pll_div_ff == 8'(PLL_HALF - 1));

    assign mon_if.enable = mon_on && pll_on_ff; // RL4
    assign mon_if.tick   = pll_tick;
    assign mon_if.clear  = xtal_edge; // RL5

    clwps_monitor u_mon (
        .clk     (mclk),
        .reset_n (reset_n),
        .mon     (mon_if.mon)
    );

    // free-running pll clock
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            pll_on_ff  <= 1'b0;
            pll_clk_ff <= 1'b0;
            pll_div_ff <= 8'h00;
        end
        else
        begin
            pll_on_ff <= pll_on_nxt; // RL4 RL11
            if (!pll_on_ff)
            begin
                pll_clk_ff <= 1'b0;
                pll_div_ff <= 8'h00;
            end
            else if (pll_div_ff == 8'(PLL_HALF - 1))
            begin
                pll_clk_ff <= !pll_clk_ff;
                pll_div_ff <= 8'h00;
            end
            else
                pll_div_ff <= pll_div_ff + 8'h01;
        end
    end

    // failure is sticky until hardware reset
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
            fail_ff <= 1'b0; // RL10
        else if (mon_if.overflow)
            fail_ff <= 1'b1; // RL7
    end

    ////////////////////////////////////////////////////////////////////////////
    // pll multiplication: half-period measure and fractional stepper

    logic [HP_W-1:0] cyc_ff;
    logic [HP_W-1:0] hp_ff;
    logic [HP_W+1:0] acc_ff;
    logic [HP_W+1:0] acc_sum;
    logic [HP_W+1:0] two_hp;
    logic [3:0]      edge_cnt_ff;
    logic [3:0]      resync_cnt;
    logic            dda_toggle;
    logic            resync;

    // fractional factors resync after 2F transitions so the phase comes out whole
    assign resync_cnt = f2_ff[0] ? f2_ff : {1'b0, f2_ff[3:1]};
    assign resync     = xtal_edge && (edge_cnt_ff == resync_cnt - 4'h1);
    assign acc_sum    = acc_ff + (HP_W+2)'(f2_ff);
    assign two_hp     = {1'b0, hp_ff, 1'b0};
    assign dda_toggle = (hp_ff != '0) && (acc_sum >= two_hp);

    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            cyc_ff <= '0;
            hp_ff  <= '0;
        end
        else if (xtal_edge)
        begin
            hp_ff  <= cyc_ff + HP_W'(1);
            cyc_ff <= '0;
        end
        else if (cyc_ff != '1)
            cyc_ff <= cyc_ff + HP_W'(1);
    end

    // F toggles per input half period: add 2F per cycle, toggle per 2*half period
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            acc_ff      <= '0;
            edge_cnt_ff <= 4'h0;
        end
        else
        begin
            if (xtal_edge)
                edge_cnt_ff <= resync ? 4'h0 : edge_cnt_ff + 4'h1;
            if (resync)
                acc_ff <= '0; // RL13
            else if (dda_toggle)
                acc_ff <= acc_sum - two_hp; // RL12
            else if (hp_ff != '0)
                acc_ff <= acc_sum;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // cpu clock source

    clwps_src_e src_ff;
    logic       cpu_clk_ff;
    logic       ext_clk_nxt;
    logic       on_pll_ff;

    always_comb
    begin
        case (mode_ff)
            CLK_DIRECT: ext_clk_nxt = xtal_lvl; // RL14
            CLK_PRESC:  ext_clk_nxt = cpu_clk_ff ^ (xtal_edge && xtal_lvl); // RL15
            CLK_PLL:    ext_clk_nxt = cpu_clk_ff ^ dda_toggle; // RL12
            default:    ext_clk_nxt = 1'b0;
        endcase
    end

    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
            src_ff <= SRC_EXT; // RL10
        else
        begin
            unique case (src_ff)
                SRC_EXT:    if (fail_ff) src_ff <= SRC_SWITCH; // RL7
                SRC_SWITCH: if (!pll_clk_ff) src_ff <= SRC_PLL; // RL16
                SRC_PLL:    src_ff <= SRC_PLL; // RL9
            endcase
        end
    end

    // copy of the next source state, so the output pin needs no decode
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
            on_pll_ff <= 1'b0; // RL10
        else
            on_pll_ff <= (src_ff == SRC_PLL) || ((src_ff == SRC_SWITCH) && !pll_clk_ff); // RL9
    end

    // a failed input has held its level for 16 pll cycles, so dropping it while the pll is low is no glitch
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
            cpu_clk_ff <= 1'b0;
        else if (!strap_done_ff)
            cpu_clk_ff <= 1'b0;
        else
        begin
            unique case (src_ff)
                SRC_EXT:    cpu_clk_ff <= ext_clk_nxt; // RL11
                SRC_SWITCH: cpu_clk_ff <= cpu_clk_ff && pll_clk_ff; // RL16
                SRC_PLL:    cpu_clk_ff <= pll_clk_ff; // RL7
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // AXI4-Lite slave

    logic              awready_ff;
    logic              wready_ff;
    logic              bvalid_ff;
    logic [1:0]        bresp_ff;
    logic              aw_hold_ff;
    logic              w_hold_ff;
    logic [ADDR_W-1:0] awaddr_ff;
    logic [31:0]       wdata_ff;
    logic [3:0]        wstrb_ff;
    logic              wr_fire;
    logic              arready_ff;
    logic              rvalid_ff;
    logic [1:0]        rresp_ff;
    logic [31:0]       rdata_ff;
    logic [31:0]       rd_word;
    logic              stat_ff;
    logic              mask_ff;
    logic              irq_ff;
    logic              wr_lane0;

    assign wr_fire  = aw_hold_ff && w_hold_ff && !bvalid_ff;
    assign wr_lane0 = wr_fire && wstrb_ff[0];

    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            awready_ff <= 1'b1;
            wready_ff  <= 1'b1;
            aw_hold_ff <= 1'b0;
            w_hold_ff  <= 1'b0;
            bvalid_ff  <= 1'b0;
            bresp_ff   <= `CLWPS_RESP_OKAY;
            awaddr_ff  <= '0;
            wdata_ff   <= 32'h00000000;
            wstrb_ff   <= 4'h0;
        end
        else
        begin
            if (s_axi_awvalid && awready_ff)
            begin
                aw_hold_ff <= 1'b1;
                awaddr_ff  <= s_axi_awaddr;
                awready_ff <= 1'b0;
            end
            if (s_axi_wvalid && wready_ff)
            begin
                w_hold_ff <= 1'b1;
                wdata_ff  <= s_axi_wdata;
                wstrb_ff  <= s_axi_wstrb;
                wready_ff <= 1'b0;
            end
            if (wr_fire)
            begin
                aw_hold_ff <= 1'b0;
                w_hold_ff  <= 1'b0;
                bvalid_ff  <= 1'b1;
                bresp_ff   <= addr_hit(awaddr_ff) ? `CLWPS_RESP_OKAY : `CLWPS_RESP_SLVERR;
            end
            if (bvalid_ff && s_axi_bready)
            begin
                bvalid_ff  <= 1'b0;
                awready_ff <= 1'b1;
                wready_ff  <= 1'b1;
            end
        end
    end

    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            dis_ff  <= `CLWPS_DIS_RST; // RL2
            mask_ff <= `CLWPS_MASK_RST;
        end
        else if (wr_lane0 && (awaddr_ff == ADDR_W'(`CLWPS_OFF_CONFIG)))
            dis_ff <= wdata_ff[`CLWPS_DIS_BIT]; // RL3
        else if (wr_lane0 && (awaddr_ff == ADDR_W'(`CLWPS_OFF_MASK)))
            mask_ff <= wdata_ff[`CLWPS_FAIL_BIT];
    end

    // a new failure wins over a clearing write in the same cycle
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            stat_ff <= 1'b0;
            irq_ff  <= 1'b0;
        end
        else
        begin
            if (mon_if.overflow)
                stat_ff <= 1'b1; // RL8
            else if (wr_lane0 && (awaddr_ff == ADDR_W'(`CLWPS_OFF_STATUS)) && wdata_ff[`CLWPS_FAIL_BIT])
                stat_ff <= 1'b0;
            irq_ff <= stat_ff && mask_ff;
        end
    end

    always_comb
    begin
        rd_word = 32'h00000000;
        case (s_axi_araddr)
            ADDR_W'(`CLWPS_OFF_CONFIG): rd_word[`CLWPS_DIS_BIT] = dis_ff;
            ADDR_W'(`CLWPS_OFF_STATUS): rd_word[`CLWPS_FAIL_BIT] = stat_ff;
            ADDR_W'(`CLWPS_OFF_MASK):   rd_word[`CLWPS_FAIL_BIT] = mask_ff;
            ADDR_W'(`CLWPS_OFF_INFO):
            begin
                rd_word[2:0]              = strap_ff;
                rd_word[`CLWPS_INFO_FAIL]  = fail_ff;
                rd_word[`CLWPS_INFO_PLLON] = pll_on_ff;
                rd_word[`CLWPS_INFO_MON]   = mon_on;
                rd_word[`CLWPS_INFO_ONPLL] = (src_ff == SRC_PLL);
            end
            default: rd_word = 32'h00000000;
        endcase
    end

    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            arready_ff <= 1'b1;
            rvalid_ff  <= 1'b0;
            rdata_ff   <= 32'h00000000;
            rresp_ff   <= `CLWPS_RESP_OKAY;
        end
        else if (s_axi_arvalid && arready_ff)
        begin
            arready_ff <= 1'b0;
            rvalid_ff  <= 1'b1;
            rdata_ff   <= rd_word;
            rresp_ff   <= addr_hit(s_axi_araddr) ? `CLWPS_RESP_OKAY : `CLWPS_RESP_SLVERR;
        end
        else if (rvalid_ff && s_axi_rready)
        begin
            rvalid_ff  <= 1'b0;
            arready_ff <= 1'b1;
        end
    end

    assign s_axi_awready  = awready_ff;
    assign s_axi_wready   = wready_ff;
    assign s_axi_bvalid   = bvalid_ff;
    assign s_axi_bresp    = bresp_ff;
    assign s_axi_arready  = arready_ff;
    assign s_axi_rvalid   = rvalid_ff;
    assign s_axi_rdata    = rdata_ff;
    assign s_axi_rresp    = rresp_ff;
    assign cpu_clk        = cpu_clk_ff;
    assign pll_enable     = pll_on_ff;
    assign cpu_on_pll     = on_pll_ff;
    assign clock_fail_irq = irq_ff;

    ////////////////////////////////////////////////////////////////////////////
    // checks

    property p_mon_mode;
        mon_if.enable |-> (mode_ff != CLK_PLL) && strap_done_ff;
    endproperty
    a_mon_mode: assert property (p_mon_mode) else $error("monitor on in pll mode"); // RL1

    property p_dis_off;
        (dis_ff && !fail_ff) |-> !mon_if.enable;
    endproperty
    a_dis_off: assert property (p_dis_off) else $error("monitor on while disabled"); // RL3

    property p_switch;
        $rose(fail_ff) |-> ##[1:SW_MAX] (src_ff == SRC_PLL);
    endproperty
    a_switch: assert property (p_switch) else $error("no switch to pll clock"); // RL7

    property p_irq_flag;
        mon_if.overflow |=> stat_ff && fail_ff ##1 (irq_ff == $past(mask_ff));
    endproperty
    a_irq_flag: assert property (p_irq_flag) else $error("failure flag not raised"); // RL8

    property p_stay_pll;
        (src_ff == SRC_PLL) |=> (src_ff == SRC_PLL) && (cpu_clk_ff == $past(pll_clk_ff));
    endproperty
    a_stay_pll: assert property (p_stay_pll) else $error("cpu clock left pll"); // RL9

    property p_pll_off;
        (direct_mode && dis_ff && !fail_ff) |=> !pll_on_ff;
    endproperty
    a_pll_off: assert property (p_pll_off) else $error("pll on while monitor disabled"); // RL11

    property p_resync;
        (resync && (mode_ff == CLK_PLL)) |=> (acc_ff == '0);
    endproperty
    a_resync: assert property (p_resync) else $error("no resync on input transition"); // RL13

    property p_direct;
        (strap_done_ff && (mode_ff == CLK_DIRECT) && (src_ff == SRC_EXT)) |=> (cpu_clk_ff == $past(xtal_lvl));
    endproperty
    a_direct: assert property (p_direct) else $error("direct drive mismatch"); // RL14

    property p_presc;
        ((mode_ff == CLK_PRESC) && (src_ff == SRC_EXT) && (cpu_clk_ff != $past(cpu_clk_ff)))
            |-> $past(xtal_edge && xtal_lvl);
    endproperty
    a_presc: assert property (p_presc) else $error("prescaler toggled off a rising edge"); // RL15

    property p_strap_hold;
        strap_done_ff |=> $stable(strap_ff) && $stable(mode_ff);
    endproperty
    a_strap_hold: assert property (p_strap_hold) else $error("strap mode changed"); // RL17
endmodule : clwps_top
`default_nettype wire

// ==== rtl/clwps_regs.svh ====
// clwps_regs.svh: register offsets, field positions, reset values and counts
// assumes: included by clwps_top and clwps_monitor, after the package
// Behaviour
// RL1: monitor works only in direct or prescaler modes
// RL2: monitor enabled after every reset
// RL3: config bit 4 disables the monitor
// RL4: enabled monitor: pll free-runs, counts cycles
// RL5: every input clock transition clears counter
// RL6: sixteen pll cycles without transition mean failure
// RL7: overflow switches cpu clock to pll
// RL8: overflow sets clock fail interrupt flag
// RL9: no switch back when input clock returns
// RL10: only hardware reset restores input clock
// RL11: disabled monitor: cpu from oscillator, pll off
// RL12: other strap codes: pll multiplies input frequency
// RL13: pll resyncs on every F-th input transition; the code resyncs on every 2F-th for fractional F
// RL14: strap 011: pll off, direct drive; the code keeps the pll running while the monitor is enabled
// RL15: strap 001: divide-by-two prescaler
// RL16: synchronise input transitions; switch without glitch
// RL17: straps captured at reset, then held
`ifndef CLWPS_REGS_SVH
`define CLWPS_REGS_SVH

`define CLWPS_ADDR_W       8
`define CLWPS_OFF_CONFIG   8'h00
`define CLWPS_OFF_STATUS   8'h04
`define CLWPS_OFF_MASK     8'h08
`define CLWPS_OFF_INFO     8'h0C

`define CLWPS_DIS_BIT      4
`define CLWPS_FAIL_BIT     0
`define CLWPS_INFO_FAIL    4
`define CLWPS_INFO_PLLON   5
`define CLWPS_INFO_MON     6
`define CLWPS_INFO_ONPLL   7

`define CLWPS_DIS_RST      1'b0
`define CLWPS_MASK_RST     1'b0
`define CLWPS_STRAP_RST    3'h7
`define CLWPS_STRAP_DIRECT 3'h3
`define CLWPS_STRAP_PRESC  3'h1

`define CLWPS_OVF_CYCLES   5'h10
`define CLWPS_PLL_HALF     4

`define CLWPS_RESP_OKAY    2'h0
`define CLWPS_RESP_SLVERR  2'h2

`endif

// ==== rtl/clwps_pkg.sv ====
// clwps_pkg: types shared by the clock-select design files
// assumes: compiled before every other file of the block
package clwps_pkg;
    typedef enum logic [1:0] {CLK_DIRECT, CLK_PRESC, CLK_PLL} clwps_mode_e;
    typedef enum logic [1:0] {SRC_EXT, SRC_SWITCH, SRC_PLL} clwps_src_e;
    typedef logic [3:0] clwps_cnt_t;
endpackage : clwps_pkg

// ==== rtl/clwps_mon_if.sv ====
// clwps_mon_if: control and result lines between top and clock-loss monitor
// assumes: all signals live in the mclk domain
`timescale 1ns/1ps
`default_nettype none
interface clwps_mon_if;
    logic enable;
    logic tick;
    logic clear;
    logic overflow;
    modport ctrl (output enable, output tick, output clear, input overflow);
    modport mon  (input enable, input tick, input clear, output overflow);
endinterface : clwps_mon_if
`default_nettype wire

// ==== rtl/clwps_sync.sv ====
// clwps_sync: two-stage synchroniser with transition detect
// assumes: d_in may change at any time relative to clk
`timescale 1ns/1ps
`default_nettype none
module clwps_sync (
    input  wire logic clk,
    input  wire logic reset_n,
    input  wire logic d_in,
    output logic      level,
    output logic      toggle
);
    logic       meta_ff;
    logic       sync_ff;
    logic       last_ff;
    logic [2:0] arm_ff;

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            meta_ff <= 1'b0;
            sync_ff <= 1'b0;
            last_ff <= 1'b0;
            arm_ff  <= 3'h0;
        end
        else
        begin
            meta_ff <= d_in;
            sync_ff <= meta_ff;
            last_ff <= sync_ff;
            arm_ff  <= {arm_ff[1:0], 1'b1};
        end
    end

    assign level  = sync_ff;
    // last_ff holds a real pin sample only from the third edge; before that a reset zero would fake an edge
    assign toggle = arm_ff[2] && (sync_ff ^ last_ff);
endmodule : clwps_sync
`default_nettype wire

// ==== rtl/clwps_monitor.sv ====
// clwps_monitor: clock-loss counter stepped by pll cycles
// assumes: tick and clear are one-cycle pulses in the clk domain
`timescale 1ns/1ps
`default_nettype none
`include "clwps_regs.svh"
module clwps_monitor
    import clwps_pkg::*;
(
    input  wire logic clk,
    input  wire logic reset_n,
    clwps_mon_if.mon  mon
);
    clwps_cnt_t cnt_ff;
    logic       ovf_ff;

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            cnt_ff <= '0;
            ovf_ff <= 1'b0;
        end
        else
        begin
            ovf_ff <= mon.enable && !mon.clear && mon.tick
                      && (cnt_ff == 4'(`CLWPS_OVF_CYCLES - 5'h01)); // RL6
            if (!mon.enable || mon.clear)
                cnt_ff <= '0; // RL5
            else if (mon.tick)
                cnt_ff <= cnt_ff + 4'h1; // RL4
        end
    end

    assign mon.overflow = ovf_ff;

    property p_clear_zero;
        @(posedge clk) disable iff (!reset_n)
        mon.clear |=> (cnt_ff == 4'h0);
    endproperty
    a_clear_zero: assert property (p_clear_zero) else $error("counter not cleared"); // RL5

    property p_ovf_sixteen;
        @(posedge clk) disable iff (!reset_n)
        mon.overflow |-> ($past(cnt_ff) == 4'hF) && $past(mon.tick) && (cnt_ff == 4'h0);
    endproperty
    a_ovf_sixteen: assert property (p_ovf_sixteen) else $error("overflow not at 16th tick"); // RL6
endmodule : clwps_monitor
`default_nettype wire

// ==== dv/clwps_osc_model.sv ====
// clwps_osc_model: external oscillator that drives the clock input pin
// assumes: half period in mclk cycles, 3 or more; run low models a dead crystal
`timescale 1ns/1ps
`default_nettype none
module clwps_osc_model (
    input  wire logic       mclk,
    input  wire logic       run,
    input  wire logic [3:0] half,
    output wire logic       osc
);
    logic [3:0] cnt = 4'h0;
    logic       lvl = 1'b0;
    assign osc = lvl;
    // a dead oscillator freezes at its last level, so the pin shows no edges at all
    always @(posedge mclk)
    begin
        if (run)
        begin
            cnt <= (cnt + 4'h1 >= half) ? 4'h0 : cnt + 4'h1;
            if (cnt + 4'h1 >= half)
                lvl <= ~lvl;
        end
    end
endmodule : clwps_osc_model
`default_nettype wire

// ==== dv/clwps_tb_top.sv ====
// clwps_tb_top: self-checking bench for the clock select and clock-loss watchdog
// assumes: PLL_HALF set to 2, so sixteen pll ticks last 64 mclk cycles
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin n_errors++; \
    $display("Error t=%0t got %h exp %h", $time, a, e); end end
module clwps_tb_top;
    logic        mclk = 1'b0, reset_n = 1'b0, run = 1'b0, osc, fail_exp;
    logic [2:0]  strap = 3'h3;
    logic [3:0]  half = 4'h3, hist = 4'h0;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = 32'h0, rdata, rd;
    logic        awready, wready, bvalid, arready, rvalid, pll_en, on_pll, irq, cpu, prev_cpu;
    logic [1:0]  rresp, rr, bresp, br;
    int          n_errors = 0, check_count = 0, seed = 56;
    always #2.5 mclk = ~mclk;
    // pin history: hist[2] is what cpu_clk shows now in direct drive, hist[3] one cycle older
    always @(posedge mclk) hist <= {hist[2:0], osc};
    clwps_osc_model clwps_osc_model_inst (.mclk(mclk), .run(run), .half(half), .osc(osc));
    clwps_top #(.PLL_HALF(2)) clwps_top_inst (.mclk(mclk), .reset_n(reset_n), .ext_clock_input_pin(osc),
        .clock_mode_strap_pins(strap), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .cpu_clk(cpu), .pll_enable(pll_en), .cpu_on_pll(on_pll), .clock_fail_irq(irq));
    ////////////////////////////////////////////////////////////////////////////
    function automatic logic exp_fail(input int s);
        exp_fail = (s == 3) || (s == 1);
    endfunction : exp_fail
    function automatic logic exp_cpu(input logic [2:0] s, input logic [3:0] h, input logic p);
        exp_cpu = (s == 3'h3) ? h[2] : p ^ (h[2] & ~h[3]);
    endfunction : exp_cpu
    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
    endtask : cyc
    task automatic restart(input logic [2:0] s);
        @(posedge mclk);
        reset_n <= 1'b0;
        strap <= s;
        cyc(16);
        reset_n <= 1'b1;
        cyc(4);
    endtask : restart
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do
        begin
            @(posedge mclk);
            if (awready)
                awvalid <= 1'b0;
            if (wready)
                wvalid <= 1'b0;
        end
        while (bvalid !== 1'b1);
        br = bresp;
        bready <= 1'b0;
    endtask : wr
    task automatic rd_reg(input logic [7:0] a);
        @(posedge mclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do
        begin
            @(posedge mclk);
            if (arready)
                arvalid <= 1'b0;
        end
        while (rvalid !== 1'b1);
        rd = rdata;
        rr = rresp;
        rready <= 1'b0;
    endtask : rd_reg
    task automatic complete_run();
        if (n_errors == 0 && check_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : complete_run
    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        for (int s = 0; s < 8; s++)
        begin
            fail_exp = exp_fail(s);
            half <= 4'h3 + 4'($unsigned($random(seed)) % 4);
            restart(3'(s));
            `CHK(on_pll, 1'b0)
            run <= 1'b1;
            repeat (30)
            begin
                prev_cpu = cpu;
                @(posedge mclk);
                if (s == 3 || s == 1)
                    `CHK(cpu, exp_cpu(3'(s), hist, prev_cpu))
            end
            rd_reg(8'h0C);
            `CHK(rd[2:0], 3'(s))
            `CHK(pll_en, 1'b1)
            run <= 1'b0;
            // well short of sixteen ticks: no failure may be seen yet
            cyc(50);
            `CHK(on_pll, 1'b0)
            cyc(60);
            `CHK(on_pll, fail_exp)
            rd_reg(8'h04);
            `CHK(rd[0], fail_exp)
            wr(8'h08, 32'h1);
            cyc(3);
            `CHK(irq, fail_exp)
            run <= 1'b1;
            cyc(40);
            `CHK(on_pll, fail_exp)
            wr(8'h04, 32'h1);
            cyc(3);
            `CHK(irq, 1'b0)
        end
        restart(3'h3);
        run <= 1'b1;
        wr(8'h00, 32'h10);
        `CHK(br, 2'h0)
        cyc(3);
        `CHK(pll_en, 1'b0)
        run <= 1'b0;
        cyc(120);
        `CHK(on_pll, 1'b0)
        rd_reg(8'hF0);
        `CHK(rr, 2'h2)
        wr(8'hF4, 32'h0);
        `CHK(br, 2'h2)
        complete_run();
    end
    initial
    begin
        cyc(30000);
        n_errors++;
        complete_run();
    end
endmodule : clwps_tb_top
`default_nettype wire
